// ==== hdl/interrupt_enable_flags.sv ====
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "irq_regs.svh"

module interrupt_enable_flags
(
    // Clock and reset
    input  wire logic          CLK,
    input  wire logic          RSTN,
    // Register port
    input  wire irq_pkg::addr_t ADDR,
    input  wire irq_pkg::reg8_t WR_DATA,
    input  wire logic          WR_EN,
    input  wire logic          RD_EN,
    output irq_pkg::reg8_t     RD_DATA,
    // External interrupt pins
    input  wire logic          EXT_INT_PIN_ZERO,
    input  wire logic          EXT_INT_PIN_ONE,
    input  wire logic          EXT_INT_PIN_THREE,
    input  wire logic          EXT_INT_PIN_FOUR,
    input  wire logic          EVENT_COUNTER_INT_PIN,
    // Flags raised by other blocks
    input  wire logic          CLOCK_CALENDAR_REQ,
    input  wire irq_pkg::reg8_t WAKE_PIN_FLAGS,
    input  wire logic          DIRECT_TRANSITION_REQ,
    input  wire logic          CONVERTER_REQ,
    input  wire logic          TIMER_HIGH_REQ,
    input  wire logic          TIMER_LOW_REQ,
    input  wire logic          EVENT_COUNTER_REQ,
    // Gated requests to the processor
    output logic               CLOCK_CALENDAR_IRQ,
    output irq_pkg::reg8_t     WAKE_PIN_IRQ,
    output logic               EXT_PIN0_IRQ,
    output logic               EXT_PIN1_IRQ,
    output logic               EXT_PIN3_IRQ,
    output logic               EXT_PIN4_IRQ,
    output logic               COUNTER_PIN_IRQ,
    output logic               DIRECT_TRANSITION_IRQ,
    output logic               CONVERTER_IRQ,
    output logic               TIMER_HIGH_IRQ,
    output logic               TIMER_LOW_IRQ,
    output logic               EVENT_COUNTER_IRQ
);
    import irq_pkg::*;

    reg8_t en_one_q;
    reg8_t en_one_d;
    reg8_t en_two_q;
    reg8_t en_two_d;
    pins_t flag_q;
    pins_t flag_d;
    pins_t edge_sel_q;
    pins_t pin_func_q;
    pins_t pin_meta_q;
    pins_t pin_sync_q;
    pins_t pin_last_q;
    pins_t pin_in;
    pins_t edge_hit;
    pins_t flag_clear;
    reg8_t rd_mux;
    reg8_t rd_q;
    logic  irq_rtc_q;
    reg8_t irq_wake_q;
    pins_t irq_pin_q;
    logic  irq_dt_q;
    logic  irq_ad_q;
    logic  irq_th_q;
    logic  irq_tl_q;
    logic  irq_ec_q;

    wire sel_en_one = (ADDR == `OFS_INT_ENABLE_ONE);
    wire sel_en_two = (ADDR == `OFS_INT_ENABLE_TWO);
    wire sel_req    = (ADDR == `OFS_INT_REQUEST_ONE);
    wire sel_edge   = (ADDR == `OFS_EDGE_SELECT);
    wire sel_func   = (ADDR == `OFS_PIN_FUNCTION);
    wire wr_en_one  = WR_EN && sel_en_one;
    wire wr_en_two  = WR_EN && sel_en_two;
    wire wr_req     = WR_EN && sel_req;
    wire wr_edge    = WR_EN && sel_edge;
    wire wr_func    = WR_EN && sel_func;

    assign pin_in[`BIT_EXT_PIN0]    = EXT_INT_PIN_ZERO;
    assign pin_in[`BIT_EXT_PIN1]    = EXT_INT_PIN_ONE;
    assign pin_in[`BIT_COUNTER_PIN] = EVENT_COUNTER_INT_PIN;
    assign pin_in[`BIT_EXT_PIN3]    = EXT_INT_PIN_THREE;
    assign pin_in[`BIT_EXT_PIN4]    = EXT_INT_PIN_FOUR;

    // Reserved-one bits are not stored, so writes cannot clear them
    // bit 5 stored
    assign en_one_d = wr_en_one ? (WR_DATA & `WMASK_INT_ENABLE_ONE)
                                : en_one_q;
    assign en_two_d = wr_en_two ? (WR_DATA & `WMASK_INT_ENABLE_TWO)
                                : en_two_q;

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            en_one_q <= `RST_INT_ENABLE_ONE;
        else
            en_one_q <= en_one_d;
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            en_two_q <= `RST_INT_ENABLE_TWO;
        else
            en_two_q <= en_two_d;
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            edge_sel_q <= pins_t'(`RST_EDGE_SELECT);
        else if (wr_edge)
            edge_sel_q <= pins_t'(WR_DATA & `WMASK_PIN_BITS);
    end

    // Pins left as ports raise nothing until software opts in
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            pin_func_q <= pins_t'(`RST_PIN_FUNCTION);
        else if (wr_func)
            pin_func_q <= pins_t'(WR_DATA & `WMASK_PIN_BITS);
    end

    // Pins are asynchronous; edge logic reads the second and third stages, never the first
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            // Idle-high history, so no false rising edge after reset
            pin_meta_q <= '1;
            pin_sync_q <= '1;
            pin_last_q <= '1;
        end
        else
        begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
            pin_last_q <= pin_sync_q;
        end
    end

    assign flag_clear = wr_req ? ~WR_DATA[`PIN_COUNT-1:0] : '0;

    genvar gi;
    generate
        for (gi = 0; gi < `PIN_COUNT; gi++)
        begin : g_pin
            wire rise = pin_sync_q[gi] && !pin_last_q[gi];
            wire fall = !pin_sync_q[gi] && pin_last_q[gi];
            assign edge_hit[gi] = pin_func_q[gi] &&
                                  (edge_sel_q[gi] ? rise : fall);
            assign flag_d[gi] = edge_hit[gi] ||
                                (flag_q[gi] && !flag_clear[gi]);
        end
    endgenerate

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            flag_q <= pins_t'(`RST_INT_REQUEST_ONE);
        else
            flag_q <= flag_d;
    end

    assign rd_mux =
        sel_en_one ? (en_one_q | `ONES_INT_ENABLE_ONE) :
        sel_en_two ? (en_two_q | `ONES_INT_ENABLE_TWO) :
        sel_req    ? ({3'h0, flag_q} | `ONES_INT_REQUEST_ONE) :
        sel_edge   ? {3'h0, edge_sel_q} :
        sel_func   ? {3'h0, pin_func_q} :
                     8'h00;

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            rd_q <= 8'h00;
        else
            rd_q <= RD_EN ? rd_mux : 8'h00;
    end

    // Enable fields, named once so the gates read plainly
    wire        en_rtc  = en_one_q[`BIT_CLOCK_CALENDAR_EN];
    wire        en_wake = en_one_q[`BIT_WAKE_GROUP_EN];
    wire pins_t en_pins = en_one_q[`PIN_COUNT-1:0];
    wire        en_dt   = en_two_q[`BIT_DIRECT_TRANS_EN];
    wire        en_ad   = en_two_q[`BIT_CONVERTER_EN];
    wire        en_th   = en_two_q[`BIT_TIMER_HIGH_EN];
    wire        en_tl   = en_two_q[`BIT_TIMER_LOW_EN];
    wire        en_ec   = en_two_q[`BIT_EVENT_COUNTER_EN];

    wire        gate_rtc  = CLOCK_CALENDAR_REQ && en_rtc;

    wire reg8_t gate_wake = WAKE_PIN_FLAGS & {8{en_wake}};

    wire pins_t gate_pin  = flag_q & en_pins;

    wire        gate_dt   = DIRECT_TRANSITION_REQ && en_dt;

    wire        gate_ad   = CONVERTER_REQ && en_ad;

    wire        gate_th   = TIMER_HIGH_REQ && en_th;

    wire        gate_tl   = TIMER_LOW_REQ && en_tl;

    wire        gate_ec   = EVENT_COUNTER_REQ && en_ec;

    // Gating adds one cycle so every output leaves a flip-flop
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            irq_rtc_q <= 1'b0;
        else
            irq_rtc_q <= gate_rtc;
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            irq_wake_q <= 8'h00;
        else
            irq_wake_q <= gate_wake;
    end

    // Levels follow the sticky flags, not the pin pulses
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            irq_pin_q <= '0;
        else
            irq_pin_q <= gate_pin;
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            irq_dt_q <= 1'b0;
        else
            irq_dt_q <= gate_dt;
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            irq_ad_q <= 1'b0;
        else
            irq_ad_q <= gate_ad;
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            irq_th_q <= 1'b0;
        else
            irq_th_q <= gate_th;
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            irq_tl_q <= 1'b0;
        else
            irq_tl_q <= gate_tl;
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            irq_ec_q <= 1'b0;
        else
            irq_ec_q <= gate_ec;
    end

    assign RD_DATA               = rd_q;
    assign CLOCK_CALENDAR_IRQ    = irq_rtc_q;
    assign WAKE_PIN_IRQ          = irq_wake_q;
    assign EXT_PIN0_IRQ          = irq_pin_q[`BIT_EXT_PIN0];
    assign EXT_PIN1_IRQ          = irq_pin_q[`BIT_EXT_PIN1];
    assign COUNTER_PIN_IRQ       = irq_pin_q[`BIT_COUNTER_PIN];
    assign EXT_PIN3_IRQ          = irq_pin_q[`BIT_EXT_PIN3];
    assign EXT_PIN4_IRQ          = irq_pin_q[`BIT_EXT_PIN4];
    assign DIRECT_TRANSITION_IRQ = irq_dt_q;
    assign CONVERTER_IRQ         = irq_ad_q;
    assign TIMER_HIGH_IRQ        = irq_th_q;
    assign TIMER_LOW_IRQ         = irq_tl_q;
    assign EVENT_COUNTER_IRQ     = irq_ec_q;

endmodule : interrupt_enable_flags

// ==== common/irq_regs.svh ====
`ifndef IRQ_REGS_SVH
`define IRQ_REGS_SVH

// Register offsets
`define OFS_INT_ENABLE_ONE  3'h0
`define OFS_INT_ENABLE_TWO  3'h1
`define OFS_INT_REQUEST_ONE 3'h2
`define OFS_EDGE_SELECT     3'h3
`define OFS_PIN_FUNCTION    3'h4

// First enable register fields
`define BIT_CLOCK_CALENDAR_EN 7
`define BIT_WAKE_GROUP_EN     5
`define BIT_EXT_PIN4_EN       4
`define BIT_EXT_PIN3_EN       3
`define BIT_COUNTER_PIN_EN    2
`define BIT_EXT_PIN1_EN       1
`define BIT_EXT_PIN0_EN       0

// Second enable register fields
`define BIT_DIRECT_TRANS_EN   7
`define BIT_CONVERTER_EN      6
`define BIT_TIMER_HIGH_EN     3
`define BIT_TIMER_LOW_EN      2
`define BIT_EVENT_COUNTER_EN  0

// Request register and per-pin fields
`define BIT_EXT_PIN4          4
`define BIT_EXT_PIN3          3
`define BIT_COUNTER_PIN       2
`define BIT_EXT_PIN1          1
`define BIT_EXT_PIN0          0
`define PIN_COUNT             5

// Reset values
`define RST_INT_ENABLE_ONE    8'h00
`define RST_INT_ENABLE_TWO    8'h00
`define RST_INT_REQUEST_ONE   8'h00
`define RST_EDGE_SELECT       8'h00
`define RST_PIN_FUNCTION      8'h00

// Bits that read as one, and writable bits
`define ONES_INT_ENABLE_ONE   8'h40
`define ONES_INT_ENABLE_TWO   8'h12
`define ONES_INT_REQUEST_ONE  8'he0
`define WMASK_INT_ENABLE_ONE  8'hbf
`define WMASK_INT_ENABLE_TWO  8'hed
`define WMASK_PIN_BITS        8'h1f

`endif

// ==== common/irq_pkg.sv ====
package irq_pkg;

    typedef logic [2:0] addr_t;
    typedef logic [7:0] reg8_t;
    typedef logic [4:0] pins_t;

endpackage : irq_pkg

// ==== testbench/irq_assertions.sv ====
`timescale 1ns/10ps
module irq_chk
(
    // Clock, reset and register port
    input wire logic           CLK,
    input wire logic           RSTN,
    input wire irq_pkg::addr_t ADDR,
    input wire irq_pkg::reg8_t WR_DATA,
    input wire logic           WR_EN,
    input wire logic           RD_EN,
    input wire irq_pkg::reg8_t RD_DATA,
    // Request inputs
    input wire logic           CLOCK_CALENDAR_REQ,
    input wire irq_pkg::reg8_t WAKE_PIN_FLAGS,
    input wire logic           DIRECT_TRANSITION_REQ,
    input wire logic           CONVERTER_REQ,
    input wire logic           TIMER_HIGH_REQ,
    input wire logic           TIMER_LOW_REQ,
    input wire logic           EVENT_COUNTER_REQ,
    // Gated outputs
    input wire logic           CLOCK_CALENDAR_IRQ,
    input wire irq_pkg::reg8_t WAKE_PIN_IRQ,
    input wire logic           EXT_PIN0_IRQ,
    input wire logic           EXT_PIN1_IRQ,
    input wire logic           EXT_PIN3_IRQ,
    input wire logic           EXT_PIN4_IRQ,
    input wire logic           COUNTER_PIN_IRQ,
    input wire logic           DIRECT_TRANSITION_IRQ,
    input wire logic           CONVERTER_IRQ,
    input wire logic           TIMER_HIGH_IRQ,
    input wire logic           TIMER_LOW_IRQ,
    input wire logic           EVENT_COUNTER_IRQ
);
    import irq_pkg::*;
    reg8_t      en_one_q;
    reg8_t      en_two_q;
    logic [4:0] pin_irq;
    logic [4:0] sec_req;
    logic [4:0] sec_irq;
    logic [4:0] sec_en;
    assign pin_irq = {EXT_PIN4_IRQ, EXT_PIN3_IRQ, COUNTER_PIN_IRQ,
                      EXT_PIN1_IRQ, EXT_PIN0_IRQ};
    assign sec_req = {DIRECT_TRANSITION_REQ, CONVERTER_REQ, TIMER_HIGH_REQ,
                      TIMER_LOW_REQ, EVENT_COUNTER_REQ};
    assign sec_irq = {DIRECT_TRANSITION_IRQ, CONVERTER_IRQ, TIMER_HIGH_IRQ,
                      TIMER_LOW_IRQ, EVENT_COUNTER_IRQ};
    assign sec_en  = {en_two_q[7:6], en_two_q[3:2], en_two_q[0]};
    // Shadow of software intent, not of the design's registers
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            en_one_q <= 8'h00;
            en_two_q <= 8'h00;
        end
        else if (WR_EN && ADDR == 3'h0)
            en_one_q <= WR_DATA;
        else if (WR_EN && ADDR == 3'h1)
            en_two_q <= WR_DATA;
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    chk_clock_gate:
        assert property (CLOCK_CALENDAR_IRQ ==
                         $past(CLOCK_CALENDAR_REQ & en_one_q[7]))
        else $error("clock calendar request gating wrong");
    chk_wake_gate:
        assert property (WAKE_PIN_IRQ ==
                         $past(WAKE_PIN_FLAGS & {8{en_one_q[5]}}))
        else $error("wake pin request gating wrong");
    chk_second_gate:
        assert property (sec_irq == $past(sec_req & sec_en))
        else $error("second group request gating wrong");
    chk_pin_gate:
        assert property ((pin_irq & ~$past(en_one_q[4:0])) == 5'h00)
        else $error("pin request passed while disabled");
    chk_flag_hold:
        assert property (!$past(WR_EN, 2) |->
                         ($past(pin_irq) & ~pin_irq) == 5'h00)
        else $error("pin request dropped without a write");
    chk_reserved_ones:
        assert property ($past(RD_EN) |->
            ($past(ADDR) != 3'h0 || RD_DATA[6]) &&
            ($past(ADDR) != 3'h1 || (RD_DATA[4] && RD_DATA[1])))
        else $error("reserved enable bit read as zero");
    chk_request_top:
        assert property ($past(RD_EN && ADDR == 3'h2) |->
                         RD_DATA[7:5] == 3'h7)
        else $error("reserved request bits read wrong");
    chk_storage_bit:
        assert property ($past(RD_EN && ADDR == 3'h1) |->
                         RD_DATA == ($past(en_two_q) | 8'h12))
        else $error("second enable readback wrong");
    cover property (EXT_PIN4_IRQ);
    cover property (CLOCK_CALENDAR_IRQ && WAKE_PIN_IRQ != 8'h00);
    cover property ($past(RD_EN && ADDR == 3'h2) && RD_DATA[0]);
endmodule : irq_chk

bind interrupt_enable_flags irq_chk u_chk
(
    .CLK, .RSTN, .ADDR, .WR_DATA, .WR_EN, .RD_EN, .RD_DATA,
    .CLOCK_CALENDAR_REQ, .WAKE_PIN_FLAGS, .DIRECT_TRANSITION_REQ,
    .CONVERTER_REQ, .TIMER_HIGH_REQ, .TIMER_LOW_REQ, .EVENT_COUNTER_REQ,
    .CLOCK_CALENDAR_IRQ, .WAKE_PIN_IRQ, .EXT_PIN0_IRQ, .EXT_PIN1_IRQ,
    .EXT_PIN3_IRQ, .EXT_PIN4_IRQ, .COUNTER_PIN_IRQ, .DIRECT_TRANSITION_IRQ,
    .CONVERTER_IRQ, .TIMER_HIGH_IRQ, .TIMER_LOW_IRQ, .EVENT_COUNTER_IRQ
);

// ==== testbench/pin_source.sv ====
`timescale 1ns/10ps
module pin_source
(
    // Clock
    input wire logic        clk,
    // Pulse request and length
    input wire logic  [4:0] fire,
    input wire logic  [2:0] width,
    // Pin levels
    output logic      [4:0] pins
);
    logic [4:0] act_q = 5'h00;
    logic [2:0] cnt_q = 3'h0;
    // Idle high like a pulled-up pin; low pulse of width plus one cycles
    assign pins = ~act_q;
    always_ff @(posedge clk)
    begin
        if (|fire)
        begin
            act_q <= fire;
            cnt_q <= width;
        end
        else if (cnt_q != 3'h0)
            cnt_q <= cnt_q - 3'h1;
        else
            act_q <= 5'h00;
    end
endmodule : pin_source

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    import irq_pkg::*;
    logic       CLK = 1'b0;
    logic       RSTN = 1'b0;
    addr_t      ADDR = 3'h0;
    reg8_t      WR_DATA = 8'h00;
    logic       WR_EN = 1'b0;
    logic       RD_EN = 1'b0;
    reg8_t      RD_DATA;
    reg8_t      wake = 8'h00;
    logic [5:0] reqs = 6'h00;
    logic [4:0] pins;
    logic [4:0] pirq;
    logic [4:0] fire = 5'h00;
    logic [2:0] width = 3'h1;
    logic       rd_v = 1'b0;
    reg8_t      exp_q[$];
    reg8_t      rst_tbl[8] = '{8'h40, 8'h12, 8'he0, 8'h00, 8'h00, 8'h00,
                               8'h00, 8'h00};
    int         errors = 0;
    int         check_count = 0;
    reg8_t      r;
    logic [4:0] m;
    interrupt_enable_flags uut
    (
        .CLK, .RSTN, .ADDR, .WR_DATA, .WR_EN, .RD_EN, .RD_DATA,
        .EXT_INT_PIN_ZERO(pins[0]), .EXT_INT_PIN_ONE(pins[1]),
        .EVENT_COUNTER_INT_PIN(pins[2]), .EXT_INT_PIN_THREE(pins[3]),
        .EXT_INT_PIN_FOUR(pins[4]), .CLOCK_CALENDAR_REQ(reqs[5]),
        .WAKE_PIN_FLAGS(wake), .DIRECT_TRANSITION_REQ(reqs[4]),
        .CONVERTER_REQ(reqs[3]), .TIMER_HIGH_REQ(reqs[2]),
        .TIMER_LOW_REQ(reqs[1]), .EVENT_COUNTER_REQ(reqs[0]),
        .CLOCK_CALENDAR_IRQ(), .WAKE_PIN_IRQ(), .EXT_PIN0_IRQ(pirq[0]),
        .EXT_PIN1_IRQ(pirq[1]), .COUNTER_PIN_IRQ(pirq[2]),
        .EXT_PIN3_IRQ(pirq[3]), .EXT_PIN4_IRQ(pirq[4]),
        .DIRECT_TRANSITION_IRQ(), .CONVERTER_IRQ(), .TIMER_HIGH_IRQ(),
        .TIMER_LOW_IRQ(), .EVENT_COUNTER_IRQ()
    );
    pin_source u_pins (.clk(CLK), .fire(fire), .width(width), .pins(pins));
    initial
        forever #2 CLK = ~CLK;
    task automatic check(input string name, input reg8_t seen, input reg8_t e);
        check_count++;
        if (seen !== e)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, e, seen);
        end
    endtask : check
    task automatic finish_test;
        $display("checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task automatic wr(input addr_t a, input reg8_t d);
        @(posedge CLK);
        ADDR <= a;
        WR_DATA <= d;
        WR_EN <= 1'b1;
        @(posedge CLK);
        WR_EN <= 1'b0;
    endtask : wr
    task automatic rd(input addr_t a, input reg8_t e);
        exp_q.push_back(e);
        @(posedge CLK);
        ADDR <= a;
        RD_EN <= 1'b1;
        @(posedge CLK);
        RD_EN <= 1'b0;
    endtask : rd
    task automatic pulse(input logic [4:0] mask);
        @(posedge CLK);
        fire <= mask;
        width <= 3'($urandom_range(4, 1));
        @(posedge CLK);
        fire <= 5'h00;
        repeat (12) @(posedge CLK);
    endtask : pulse
    // Same-clock sources change every cycle so gating is always exercised
    always @(posedge CLK)
    begin
        reqs <= 6'($urandom);
        wake <= 8'($urandom);
    end
    // Read data stands only in the cycle after the strobe
    always @(posedge CLK)
        rd_v <= RD_EN;
    always @(negedge CLK)
        if (rd_v)
            check("rd_data", RD_DATA, exp_q.pop_front());
    initial
    begin
        void'($urandom(32'h9d2c));
        repeat (4) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (4) @(posedge CLK);
        wr(3'h6, 8'hff);
        foreach (rst_tbl[i])
            rd(3'(i), rst_tbl[i]);
        repeat (6)
        begin
            r = 8'($urandom);
            wr(3'h0, r);
            rd(3'h0, r | 8'h40);
            wr(3'h1, r);
            rd(3'h1, r | 8'h12);
        end
        wr(3'h4, 8'h1f);
        for (int i = 0; i < 10; i++)
        begin
            m = 5'h01 << (i % 5);
            wr(3'h3, {3'h0, (i >= 5) ? m : 5'h00});
            wr(3'h0, {3'h0, {5{i[0]}}});
            pulse(m);
            rd(3'h2, {3'h7, m});
            @(negedge CLK);
            check("pin_irq", {3'h0, pirq}, {3'h0, m & {5{i[0]}}});
            // Ones leave flags alone, a zero clears
            wr(3'h2, 8'hff);
            rd(3'h2, {3'h7, m});
            wr(3'h2, ~{3'h0, m});
            rd(3'h2, 8'he0);
        end
        // Pins not configured as interrupt inputs raise nothing
        wr(3'h4, 8'h00);
        pulse(5'h1f);
        rd(3'h2, 8'he0);
        repeat (4) @(posedge CLK);
        finish_test();
    end
    initial
    begin
        repeat (20000) @(posedge CLK);
        errors++;
        finish_test();
    end
endmodule : tb_top
